// ===== pmcc_top.v
/*
 * Power mode clock controller: clock source selection, high-speed
 * oscillator enable and stable flag, halt into sleep or idle, wake-up.
 * Assumes all inputs are synchronous to clk; the oscillators, watchdog
 * counter and interrupt controller sit outside and report by levels.
 */
// Contract
// - enable write clears stable flag, set later
// - oscillator enable bit zero, resets high
// - unused control bits read as zero
// - select code 111 switches to sub clock
// - slow switch completes only when sub stable
// - codes 000-110 return to divided fast clock
// - halt with both keeps low enters sleep
// - halt with low keep only: idle low
// - halt with both keeps: idle both clocks
// - halt with high keep only: idle high
// - halt stops execution, state is kept
// - halt sets powered-down, clears timeout flag
// - halt clears watchdog, resume if enabled
// - wake on port-A fall, interrupt, watchdog
// - clear-watchdog or power-up clears powered-down
// - watchdog wake sets timeout, resets pc/sp only
// - per-pin port-A wake enable, resume after halt
// - disabled or stack full: resume, keep pending
// - enabled and stack free: normal interrupt response
// - interrupt already pending at halt cannot wake
// - wake waits for system oscillator stable
// - select field bits 7-5, reset 000
// - keep bits 1 and 0, reset 0
`timescale 1ns/100ps
`include "pmcc_defines.vh"

module pmcc_top (
   input  wire       clk,
   input  wire       rstn,
   input  wire [1:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       halt_req,
   input  wire       clr_wdt,
   input  wire       wdt_enable,
   input  wire       wdt_overflow,
   input  wire       hs_osc_ready,
   input  wire       ls_osc_ready,
   input  wire       ls_tick,
   input  wire [7:0] porta_in,
   input  wire [7:0] int_req,
   input  wire [7:0] int_enable,
   input  wire       stack_full,
   output wire       hs_osc_on,
   output wire       ls_osc_on,
   output wire       sys_clk_en,
   output wire       hs_clock_en,
   output wire       sub_clk_en,
   output wire       cpu_run,
   output wire       sys_on_sub,
   output wire       wdt_clear,
   output reg        pc_sp_reset,
   output reg        int_service,
   output reg        resume_next,
   output wire [2:0] mode_state
);

   // mode sequencer states; sleep and the idles are the halted ones
   localparam [2:0] ST_RUN       = 3'h0;
   localparam [2:0] ST_SLEEP     = 3'h1;
   localparam [2:0] ST_IDLE_LO   = 3'h2;
   localparam [2:0] ST_IDLE_BOTH = 3'h3;
   localparam [2:0] ST_IDLE_HI   = 3'h4;
   localparam [2:0] ST_WAKE      = 3'h5;
   // reset image of the clock control register, sliced per field
   localparam [7:0] CLK_RST      = `PMCC_CLK_RESET;

   // software-visible state
   reg  [2:0] sel_q;
   reg        hs_keep_q;
   reg        ls_keep_q;
   reg        hs_en_q;
   reg        hs_flag_q;
   reg        pd_q;
   reg        to_q;
   reg  [7:0] wake_en_q;

   // operating state
   reg  [2:0] state_q;
   reg  [2:0] state_d;
   reg        on_sub_q;
   reg  [7:0] porta_q;
   reg  [7:0] int_old_q;
   reg        wake_wdt_q;
   reg        wake_int_q;

   wire       wr_ctl;
   wire       wr_hoc;
   wire       wr_wake;
   wire       halted;
   wire [7:0] porta_fall;
   wire [7:0] int_new;
   wire       wake_any;
   wire       div_tick;
   wire       src_ready;
   wire       hs_needed;

   // one decode used for every write strobe
   function sel_hit;
      input [1:0] addr;
      input [1:0] ofs;
      begin
         sel_hit = (addr == ofs);
      end
   endfunction

   assign wr_ctl  = reg_wr && sel_hit(reg_addr, `PMCC_OFS_CLK);
   assign wr_hoc  = reg_wr && sel_hit(reg_addr, `PMCC_OFS_HOC);
   assign wr_wake = reg_wr && sel_hit(reg_addr, `PMCC_OFS_WAKE);

   // system clock control: select and idle keep bits
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_q     <= CLK_RST[`PMCC_CLK_SEL_HI:`PMCC_CLK_SEL_LO];
         hs_keep_q <= CLK_RST[`PMCC_CLK_HS_KEEP];
         ls_keep_q <= CLK_RST[`PMCC_CLK_LS_KEEP];
      end else if (wr_ctl) begin
         sel_q     <= reg_wdata[`PMCC_CLK_SEL_HI:`PMCC_CLK_SEL_LO];
         hs_keep_q <= reg_wdata[`PMCC_CLK_HS_KEEP];
         ls_keep_q <= reg_wdata[`PMCC_CLK_LS_KEEP];
      end
   end

   // oscillator enable, powers up running
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         hs_en_q <= `PMCC_HOC_EN_RST;
      else if (wr_hoc)
         hs_en_q <= reg_wdata[`PMCC_HOC_EN];
   end

   // stable flag: an enabling write restarts it, so that write wins
   // over a ready level still high from the previous run
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         hs_flag_q <= 1'b0;
      else if (wr_hoc && reg_wdata[`PMCC_HOC_EN])
         hs_flag_q <= 1'b0;
      else if (!hs_osc_on || !hs_osc_ready)
         hs_flag_q <= 1'b0;
      else
         hs_flag_q <= 1'b1;
   end

   // per-pin port-A wake enables
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         wake_en_q <= `PMCC_WAKE_RESET;
      else if (wr_wake)
         wake_en_q <= reg_wdata;
   end

   // powered-down and timeout flags; a halt in the same cycle as a
   // clear-watchdog leaves the flag set, the event is not lost
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pd_q <= 1'b0;
         to_q <= 1'b0;
      end else begin
         if (state_q == ST_RUN && halt_req)
            pd_q <= 1'b1;
         else if (clr_wdt)
            pd_q <= 1'b0;
         if (state_q == ST_RUN && halt_req)
            to_q <= 1'b0;
         else if (halted && wdt_overflow)
            to_q <= 1'b1;
      end
   end

   // read data stand only in the cycle after the strobe
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         reg_rdata <= 8'h00;
      else if (!reg_rd)
         reg_rdata <= 8'h00;
      else begin
         case (reg_addr)
            `PMCC_OFS_CLK:
               reg_rdata <= {sel_q, 3'h0, hs_keep_q, ls_keep_q};
            `PMCC_OFS_HOC:
               reg_rdata <= {6'h00, hs_flag_q, hs_en_q};
            `PMCC_OFS_STATUS:
               reg_rdata <= {6'h00, to_q, pd_q};
            `PMCC_OFS_WAKE:
               reg_rdata <= wake_en_q;
            default:
               reg_rdata <= 8'h00;
         endcase
      end
   end

   // wake sources; pins are sampled every cycle so the edge is fresh
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         porta_q <= 8'hFF;
      else
         porta_q <= porta_in;
   end

   assign porta_fall = porta_q & ~porta_in & wake_en_q;
   // requests already raised at the halt are masked out of wake-up
   assign int_new    = int_req & ~int_old_q;
   assign halted     = (state_q == ST_SLEEP) ||
                       (state_q == ST_IDLE_LO) ||
                       (state_q == ST_IDLE_BOTH) ||
                       (state_q == ST_IDLE_HI);
   assign wake_any   = halted && ((|porta_fall) || (|int_new) ||
                       wdt_overflow);

   // snapshot of pending requests, and the wake cause
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_old_q  <= 8'h00;
         wake_wdt_q <= 1'b0;
         wake_int_q <= 1'b0;
      end else begin
         if (state_q == ST_RUN && halt_req)
            int_old_q <= int_req;
         if (wake_any) begin
            wake_wdt_q <= wdt_overflow;
            wake_int_q <= |int_new;
         end
      end
   end

   // the source needed on resume must be stable before running again
   assign src_ready = on_sub_q ? ls_osc_ready : hs_osc_ready;

   // mode sequencer; keep bits are sampled with the halt pulse
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (halt_req) begin
               case ({hs_keep_q, ls_keep_q})
                  2'b00:   state_d = ST_SLEEP;
                  2'b01:   state_d = ST_IDLE_LO;
                  2'b11:   state_d = ST_IDLE_BOTH;
                  default: state_d = ST_IDLE_HI;
               endcase
            end
         end
         ST_SLEEP, ST_IDLE_LO, ST_IDLE_BOTH, ST_IDLE_HI: begin
            if (wake_any)
               state_d = ST_WAKE;
         end
         ST_WAKE: begin
            if (src_ready)
               state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         state_q <= ST_RUN;
      else
         state_q <= state_d;
   end

   // resume pulses in the cycle that running starts again
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc_sp_reset <= 1'b0;
         int_service <= 1'b0;
         resume_next <= 1'b0;
      end else if (state_q == ST_WAKE && src_ready) begin
         pc_sp_reset <= wake_wdt_q;
         int_service <= !wake_wdt_q && wake_int_q &&
                        (|(int_req & int_enable)) &&
                        !stack_full;
         // disabled or stack full: plain resume, the request stays
         // pending in the interrupt controller until it can be taken
         resume_next <= !wake_wdt_q &&
                        !(wake_int_q && (|(int_req & int_enable)) &&
                          !stack_full);
      end else begin
         pc_sp_reset <= 1'b0;
         int_service <= 1'b0;
         resume_next <= 1'b0;
      end
   end

   // source switch: move to the sub clock only at its tick once it is stable,
   // back to the fast clock as soon as it is stable; the old source carries on meanwhile
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         on_sub_q <= 1'b0;
      else if (state_q == ST_RUN) begin
         if (!on_sub_q && sel_q == `PMCC_SEL_SUB &&
             ls_osc_ready && ls_tick)
            on_sub_q <= 1'b1;
         else if (on_sub_q && sel_q != `PMCC_SEL_SUB &&
                  hs_osc_ready)
            on_sub_q <= 1'b0;
      end
   end

   // halted states keep their oscillators as the keep bits say
   assign hs_needed = (state_q == ST_RUN) ?
                      (hs_en_q || !on_sub_q ||
                       sel_q != `PMCC_SEL_SUB) :
                      (state_q == ST_WAKE) ? !on_sub_q :
                      (state_q == ST_IDLE_BOTH) ||
                      (state_q == ST_IDLE_HI);
   assign hs_osc_on = hs_needed;
   // the low oscillator also feeds the watchdog, so it stays up in
   // sleep and idle-high while the watchdog is enabled
   assign ls_osc_on = (state_q == ST_RUN) ||
                      (state_q == ST_WAKE) ||
                      (state_q == ST_IDLE_LO) ||
                      (state_q == ST_IDLE_BOTH) ||
                      wdt_enable;

   // divided high-speed tick; held in reset while on the sub clock
   pmcc_clkdiv u_div (
      .clk  (clk),
      .rstn (rstn),
      .run  (!on_sub_q && state_q == ST_RUN),
      .code (sel_q == `PMCC_SEL_SUB ? 3'h0 : sel_q),
      .tick (div_tick)
   );

   // execution stops at the halt; nothing else is touched, so memory,
   // registers and ports hold their values
   assign cpu_run     = (state_q == ST_RUN);
   assign sys_clk_en  = cpu_run &&
                        (on_sub_q ? ls_tick : div_tick);
   assign sys_on_sub  = on_sub_q;
   assign hs_clock_en = hs_osc_on && hs_osc_ready &&
                        (state_q != ST_IDLE_LO);
   assign sub_clk_en  = ls_tick &&
                        (state_q == ST_RUN ||
                         state_q == ST_IDLE_LO ||
                         state_q == ST_IDLE_BOTH);
   // the halt clears the counter; it counts on only if enabled
   assign wdt_clear   = clr_wdt ||
                        (state_q == ST_RUN && halt_req);
   assign mode_state  = state_q;

endmodule

// ===== pmcc_defines.vh
/*
 * Constants of the power mode clock controller: register offsets,
 * field positions, reset values and mode codes.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef PMCC_DEFINES_VH
`define PMCC_DEFINES_VH

// register offsets on the plain register port
`define PMCC_OFS_CLK      2'h0
`define PMCC_OFS_HOC      2'h1
`define PMCC_OFS_STATUS   2'h2
`define PMCC_OFS_WAKE     2'h3

// system_clock_ctrl fields
`define PMCC_CLK_SEL_HI   7
`define PMCC_CLK_SEL_LO   5
`define PMCC_CLK_HS_KEEP  1
`define PMCC_CLK_LS_KEEP  0
`define PMCC_CLK_RESET    8'h00
`define PMCC_SEL_SUB      3'h7

// hs_osc_control fields
`define PMCC_HOC_FLAG     1
`define PMCC_HOC_EN       0
`define PMCC_HOC_EN_RST   1'b1

// status fields
`define PMCC_ST_PD        0
`define PMCC_ST_TO        1

// port-A wake enable reset value
`define PMCC_WAKE_RESET   8'h00

`endif

// ===== pmcc_clkdiv.v
/*
 * Divider of the high-speed clock: one-cycle tick every 2^code cycles for codes 0-6, every 64 cycles for code 7.
 * Assumes clk is the high-speed clock and code is stable per period.
 */
`timescale 1ns/100ps

module pmcc_clkdiv (
   input  wire       clk,
   input  wire       rstn,
   input  wire       run,
   input  wire [2:0] code,
   output wire       tick
);

   reg  [5:0] cnt_q;
   reg  [2:0] code_q;
   wire [5:0] limit;

   // terminal count of the latched divide code
   assign limit = (6'h01 << code_q) - 6'h01;
   assign tick  = run && (cnt_q == limit);

   // new ratio taken only at a period end or while stopped, so no runt period appears
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= 6'h00;
         code_q <= 3'h0;
      end else if (!run) begin
         cnt_q  <= 6'h00;
         code_q <= code;
      end else if (tick) begin
         cnt_q  <= 6'h00;
         code_q <= code;
      end else begin
         cnt_q  <= cnt_q + 6'h01;
      end
   end

endmodule

// ===== pmcc_osc_model.sv
/* Oscillator model for the power mode clock controller: a high-speed
   oscillator with a start-up count and a sub clock tick source.
   Assumes one system clock and an active-low asynchronous reset. */
`timescale 1ns/100ps

module pmcc_osc_model #(
   parameter [3:0] HS_START = 4'h8
) (
   input  wire clk,
   input  wire rstn,
   input  wire hs_osc_on,
   input  wire ls_osc_on,
   input  wire ls_ok,
   output wire hs_osc_ready,
   output wire ls_osc_ready,
   output wire ls_tick
);
   reg  [3:0] hs_cnt_q;
   reg  [1:0] ls_div_q;

   // ready only after the run request has stood for the start-up count,
   // so a restart after a stop is never seen as stable at once
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         hs_cnt_q <= 4'h0;
      else if (!hs_osc_on)
         hs_cnt_q <= 4'h0;
      else if (hs_cnt_q != HS_START)
         hs_cnt_q <= hs_cnt_q + 4'h1;
   end
   assign hs_osc_ready = hs_osc_on && (hs_cnt_q == HS_START);

   // sub clock period of four cycles; held at zero while stopped
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         ls_div_q <= 2'h0;
      else
         ls_div_q <= ls_osc_ready ? ls_div_q + 2'h1 : 2'h0;
   end
   assign ls_osc_ready = ls_osc_on && ls_ok;
   assign ls_tick      = ls_osc_ready && (ls_div_q == 2'h3);
endmodule

// ===== pmcc_sva.sv
/* Checker of the power mode clock controller: timing relations seen at
   the top module's ports. Assumes binding to pmcc_top, one clock. */
`timescale 1ns/100ps

module pmcc_sva (
   input wire       clk,
   input wire       rstn,
   input wire       halt_req,
   input wire       wdt_clear,
   input wire [2:0] mode_state,
   input wire       cpu_run,
   input wire       hs_osc_ready,
   input wire       ls_osc_ready,
   input wire       ls_tick,
   input wire       sys_on_sub,
   input wire       pc_sp_reset,
   input wire       int_service,
   input wire       resume_next,
   input wire       sys_clk_en,
   input wire       hs_clock_en,
   input wire       sub_clk_en,
   input wire       hs_osc_on,
   input wire       ls_osc_on
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_wdt_clear;
      halt_req && mode_state == 3'h0 |-> wdt_clear;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear)
      else $error("watchdog not cleared on halt");
   property p_halt_stop;
      halt_req && mode_state == 3'h0 |=>
         !cpu_run && mode_state inside {3'h1, 3'h2, 3'h3, 3'h4};
   endproperty
   a_halt_stop: assert property (p_halt_stop)
      else $error("halt did not stop execution");
   // the source to resume on is the one the system clock sits on
   property p_wake_wait;
      mode_state == 3'h5 &&
         !(sys_on_sub ? ls_osc_ready : hs_osc_ready) |=>
         mode_state == 3'h5;
   endproperty
   a_wake_wait: assert property (p_wake_wait)
      else $error("resumed before oscillator stable");
   property p_wake_cause;
      $rose(cpu_run) |-> $onehot({pc_sp_reset, int_service, resume_next});
   endproperty
   a_wake_cause: assert property (p_wake_cause)
      else $error("wake without exactly one resume kind");
   property p_sub_switch;
      $rose(sys_on_sub) |-> $past(ls_osc_ready && ls_tick);
   endproperty
   a_sub_switch: assert property (p_sub_switch)
      else $error("sub clock taken while not stable");
   property p_fast_back;
      $fell(sys_on_sub) |-> $past(hs_osc_ready);
   endproperty
   a_fast_back: assert property (p_fast_back)
      else $error("fast clock taken while not stable");
   property p_sleep;
      mode_state == 3'h1 |-> !sys_clk_en && !hs_clock_en && !sub_clk_en;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("clock running in sleep");
   property p_idle_low;
      mode_state == 3'h2 |-> !hs_clock_en && ls_osc_on;
   endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("wrong clocks in low-clock idle");
   property p_idle_both;
      mode_state == 3'h3 |-> hs_osc_on && ls_osc_on;
   endproperty
   a_idle_both: assert property (p_idle_both)
      else $error("wrong clocks in both-clock idle");
   property p_idle_high;
      mode_state == 3'h4 |-> hs_osc_on && !sub_clk_en;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("wrong clocks in high-clock idle");
endmodule

bind pmcc_top pmcc_sva u_sva (.clk(clk), .rstn(rstn), .halt_req(halt_req),
   .wdt_clear(wdt_clear), .mode_state(mode_state), .cpu_run(cpu_run),
   .hs_osc_ready(hs_osc_ready), .ls_osc_ready(ls_osc_ready),
   .ls_tick(ls_tick), .sys_on_sub(sys_on_sub), .pc_sp_reset(pc_sp_reset),
   .int_service(int_service), .resume_next(resume_next),
   .sys_clk_en(sys_clk_en), .hs_clock_en(hs_clock_en),
   .sub_clk_en(sub_clk_en), .hs_osc_on(hs_osc_on), .ls_osc_on(ls_osc_on));

// ===== pmcc_tb.sv
/* Bench of the power mode clock controller: registers, divider, clock
   switch, halt and wake, each judged in its own task.
   Assumes the oscillator model and the bound checker beside the design. */
`timescale 1ns/100ps
`define CHK(n,e,g) begin check_count++; \
   if ((g) !== (e)) begin errors++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end

module testbench;
   localparam [1:0] A_CLK = 2'h0, A_OSC = 2'h1, A_STAT = 2'h2, A_WAKE = 2'h3;
   reg        clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, halt_req = 0;
   reg        clr_wdt = 0, wdt_enable = 1, wdt_overflow = 0;
   reg        stack_full = 0, ls_ok = 1;
   reg  [1:0] reg_addr = 2'h0;
   reg  [7:0] reg_wdata = 8'h00, porta_in = 8'hFF;
   reg  [7:0] int_req = 8'h00, int_enable = 8'h00, d;
   reg  [2:0] cause;
   wire [7:0] reg_rdata;
   wire [2:0] mode_state;
   wire       hs_osc_on, ls_osc_on, hs_osc_ready, ls_osc_ready, ls_tick;
   wire       sys_on_sub, pc_sp_reset, int_service, resume_next, sys_clk_en;
   int        errors = 0;
   int        check_count = 0;

   // 100 MHz system clock
   always #5 clk = ~clk;

   pmcc_top DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .halt_req(halt_req), .clr_wdt(clr_wdt),
      .wdt_enable(wdt_enable), .wdt_overflow(wdt_overflow),
      .hs_osc_ready(hs_osc_ready), .ls_osc_ready(ls_osc_ready),
      .ls_tick(ls_tick), .porta_in(porta_in), .int_req(int_req),
      .int_enable(int_enable), .stack_full(stack_full),
      .hs_osc_on(hs_osc_on), .ls_osc_on(ls_osc_on), .sys_clk_en(sys_clk_en),
      .hs_clock_en(), .sub_clk_en(), .cpu_run(), .sys_on_sub(sys_on_sub),
      .wdt_clear(), .pc_sp_reset(pc_sp_reset), .int_service(int_service),
      .resume_next(resume_next), .mode_state(mode_state));

   pmcc_osc_model u_osc (.clk(clk), .rstn(rstn), .hs_osc_on(hs_osc_on),
      .ls_osc_on(ls_osc_on), .ls_ok(ls_ok), .hs_osc_ready(hs_osc_ready),
      .ls_osc_ready(ls_osc_ready), .ls_tick(ls_tick));

   task wr(input [1:0] a, input [7:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input [1:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task pulse(input int which);
      @(posedge clk);
      if (which == 0) halt_req <= 1'b1;
      else clr_wdt <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      clr_wdt  <= 1'b0;
      #1;
   endtask
   // cause pulses arrive in the cycle that run is entered again
   task wait_run;
      cause = 3'h0;
      repeat (80) begin
         @(posedge clk);
         #1;
         if (mode_state === 3'h0) begin
            cause = {pc_sp_reset, int_service, resume_next};
            break;
         end
      end
      `CHK("mode_state", 3'h0, mode_state)
   endtask
   task wait_sub(input v);
      repeat (60) begin
         @(posedge clk);
         #1;
         if (sys_on_sub === v) break;
      end
      `CHK("sys_on_sub", v, sys_on_sub)
   endtask
   // software must see the stable flag before leaning on the fast clock
   task poll_flag;
      d = 8'h00;
      repeat (40) if (d[1] !== 1'b1) rd(A_OSC);
      `CHK("stable flag", 1'b1, d[1])
   endtask

   task t_reset;
      rd(A_CLK);
      `CHK("clock ctrl reset", 8'h00, d)
      rd(A_OSC);
      `CHK("osc enable reset", 1'b1, d[0])
      `CHK("osc unused reset", 6'h00, d[7:2])
      rd(A_STAT);
      `CHK("status reset", 8'h00, d)
      poll_flag;
   endtask
   task t_div;
      int c, n;
      for (c = 0; c < 7; c++) begin
         wr(A_CLK, {c[2:0], 5'h00});
         repeat (130) @(posedge clk);
         n = 0;
         repeat (128) begin
            @(posedge clk);
            #1 n += sys_clk_en;
         end
         `CHK("ticks per 128", 128 >> c, n)
      end
   endtask
   task t_slow;
      @(posedge clk);
      ls_ok <= 1'b0;
      wr(A_CLK, 8'hE0);
      repeat (20) @(posedge clk);
      #1 `CHK("sub before ready", 1'b0, sys_on_sub)
      @(posedge clk);
      ls_ok <= 1'b1;
      wait_sub(1'b1);
      wr(A_OSC, 8'h00);
      repeat (4) @(posedge clk);
      wr(A_OSC, 8'hFD);
      rd(A_OSC);
      `CHK("flag after enable", 1'b0, d[1])
      `CHK("osc unused", 6'h00, d[7:2])
      poll_flag;
      wr(A_CLK, 8'hC0);
      wait_sub(1'b0);
   endtask
   task t_halt_modes;
      int k;
      reg [2:0] m;
      wr(A_WAKE, 8'h01);
      for (k = 0; k < 4; k++) begin
         wr(A_CLK, {6'h00, k[1:0]});
         // sleep runs with the watchdog off, so its oscillator may stop
         wdt_enable <= (k != 0);
         m = (k == 0) ? 3'h1 : (k == 1) ? 3'h2 : (k == 3) ? 3'h3 : 3'h4;
         pulse(0);
         `CHK("halt mode", m, mode_state)
         `CHK("low osc in halt", k != 0, ls_osc_on)
         rd(A_STAT);
         `CHK("pd and to", 2'b01, d[1:0])
         @(posedge clk);
         porta_in <= 8'hFD;
         repeat (10) @(posedge clk);
         #1 `CHK("disabled pin", m, mode_state)
         @(posedge clk);
         porta_in <= 8'hFC;
         wait_run;
         `CHK("pin wake cause", 3'b001, cause)
         @(posedge clk);
         porta_in <= 8'hFF;
      end
      wdt_enable <= 1'b1;
   endtask
   task t_wdt;
      wr(A_CLK, 8'h00);
      pulse(0);
      @(posedge clk);
      wdt_overflow <= 1'b1;
      @(posedge clk);
      wdt_overflow <= 1'b0;
      wait_run;
      `CHK("wdt wake cause", 3'b100, cause)
      rd(A_STAT);
      `CHK("to and pd", 2'b11, d[1:0])
      pulse(1);
      rd(A_STAT);
      `CHK("pd cleared", 2'b10, d[1:0])
   endtask
   // a request pending at halt must not wake; later ones by enable/stack
   task t_int;
      int i;
      @(posedge clk);
      int_req    <= 8'h02;
      int_enable <= 8'h06;
      pulse(0);
      repeat (10) @(posedge clk);
      #1 `CHK("pending int", 3'h1, mode_state)
      @(posedge clk);
      porta_in <= 8'hFE;
      wait_run;
      for (i = 0; i < 3; i++) begin
         @(posedge clk);
         porta_in <= 8'hFF;
         int_req  <= 8'h00;
         pulse(0);
         @(posedge clk);
         int_req    <= (i == 2) ? 8'h08 : 8'h04;
         stack_full <= (i == 1);
         wait_run;
         `CHK("int cause", i ? 3'b001 : 3'b010, cause)
         stack_full <= 1'b0;
      end
   endtask

   task finish_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_div;
      t_slow;
      t_halt_modes;
      t_wdt;
      t_int;
      finish_test;
   end
   // watchdog well past the expected few thousand cycles
   initial begin
      #300000;
      errors++;
      finish_test;
   end
endmodule
